// >>> readback_pkg.sv
// Purpose: Shared constants and types for the serial readback block
// Assumes: 24-bit command frames, optional 32-bit frames with check byte
// Notes: Field positions are bit numbers inside the 24-bit command word or a 16-bit register word
package readback_pkg;
    localparam int DATA_W = 16;
    localparam int FRAME_W = 24;
    localparam int PC_FRAME_W = 32;
    localparam int PAD_W = FRAME_W - DATA_W;
    localparam int CNT_W = 6;
    localparam int PTR_W = 5;
    localparam int SEL_W = 5;
    localparam int N_CH = 4;
    localparam int SYNC_W = 16;
    // Command word fields
    localparam int RW_POS = 23;
    localparam int ADDR_MSB = 22;
    localparam int ADDR_LSB = 21;
    localparam int SEL_MSB = 20;
    localparam int SEL_LSB = 16;
    // Read-select codes
    localparam logic [SEL_W-1:0] SEL_CLEAR_D = 5'h13;
    localparam logic [SEL_W-1:0] SEL_SLEW_A = 5'h14;
    localparam logic [SEL_W-1:0] SEL_SLEW_D = 5'h17;
    localparam logic [SEL_W-1:0] SEL_STATUS = 5'h18;
    localparam logic [SEL_W-1:0] SEL_MAIN = 5'h19;
    localparam logic [SEL_W-1:0] SEL_DCDC = 5'h1A;
    // Status word layout
    localparam int ST_BOOST_LSB = 12;
    localparam int ST_TOGGLE = 11;
    localparam int ST_PKT = 10;
    localparam int ST_RAMP = 9;
    localparam int ST_TEMP = 8;
    localparam int ST_IOUT_LSB = 0;
    localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
    // Slew register layout
    localparam int SLEW_EN_POS = 12;
    localparam int SLEW_RATE_LSB = 3;
    localparam int SLEW_RATE_W = 4;
    localparam int SLEW_STEP_LSB = 0;
    localparam int SLEW_STEP_W = 3;
    localparam logic [DATA_W-1:0] SLEW_KEEP = 16'h107F;
    localparam logic [DATA_W-1:0] SLEW_RESET = 16'h0000;
    localparam logic [FRAME_W-1:0] NO_OP_FRAME = 24'h1CE000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_REPLY = 2'b10
    } rb_state_t;
endpackage : readback_pkg

// >>> readback_if.sv
// Purpose: Carrier between the core domain and the serial link domain
// Assumes: Words are quasi-static while the side that reads them looks
// Notes: rx fields change only on link clock edges inside a frame
`timescale 1ns/100ps
interface readback_if;
    import readback_pkg::*;
    logic [PC_FRAME_W-1:0] rx_data;
    logic [CNT_W-1:0] rx_count;
    logic [FRAME_W-1:0] tx_word;
    logic tx_en;
    modport link (output rx_data, output rx_count,
                  input tx_word, input tx_en);
    modport core (input rx_data, input rx_count,
                  output tx_word, output tx_en);
endinterface : readback_if

// >>> bit_sync.sv
// Purpose: Two-flop level synchroniser, one per bit
// Assumes: Inputs are slow levels relative to the clock
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // Two stages to settle metastability before any logic reads it
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            dout <= '0;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : bit_sync

// >>> serial_link.sv
// Purpose: Shift logic on the serial clock, framed by the select line
// Assumes: Input sampled on falling edges, output changes on rising edges
// Notes: Link clock stops outside frames; select high clears the output side, while the captured data and count are kept
`timescale 1ns/100ps
module serial_link
    import readback_pkg::*;
(
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    output logic sdo,
    output logic sdo_oe,
    readback_if.link rb
);
    logic fall_seen_q;
    logic started_q;
    logic [PTR_W-1:0] ptr_q;

    // Falling edges capture input; the count restarts on the first one
    always_ff @(negedge sclk) begin
        rb.rx_data <= {rb.rx_data[PC_FRAME_W-2:0], sdin};
        if (!fall_seen_q) begin
            rb.rx_count <= CNT_W'(1);
        end else if (rb.rx_count != '1) begin
            rb.rx_count <= CNT_W'(rb.rx_count + CNT_W'(1));
        end
    end

    // Marks that a falling edge occurred in this frame
    always_ff @(negedge sclk or posedge sync_n) begin
        if (sync_n) begin
            fall_seen_q <= 1'b0;
        end else begin
            fall_seen_q <= 1'b1;
        end
    end

    // Rising edges walk the reply word; a falling-first frame skips one bit
    always_ff @(posedge sclk or posedge sync_n) begin
        if (sync_n) begin
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
            started_q <= 1'b0;
            ptr_q <= '0;
        end else if (!started_q) begin
            started_q <= 1'b1;
            sdo_oe <= rb.tx_en;
            sdo <= fall_seen_q ? rb.tx_word[FRAME_W-2]
                               : rb.tx_word[FRAME_W-1];
            ptr_q <= fall_seen_q ? PTR_W'(FRAME_W-3) : PTR_W'(FRAME_W-2);
        end else begin
            sdo <= rb.tx_word[ptr_q];
            if (ptr_q != '0) begin
                ptr_q <= PTR_W'(ptr_q - PTR_W'(1));
            end
        end
    end
endmodule : serial_link

// >>> serial_readback_status_regs.sv
// Purpose: Readback path, status word and per-channel slew registers
// Assumes: Select high at least 4 core clocks between frames, and at
//          least 3 core clocks from select low to the first link edge
// Notes: The reply word is frozen while a frame is in progress
`timescale 1ns/100ps
// What this block does
// - Top frame bit set marks a read command instead of a write.
// - Address bits 22:21 must match the straps; select bits 20:16 pick the register.
// - Low sixteen bits of a read command are ignored.
// - Selected register goes out during the next frame, not this one.
// - Register value sits in the low sixteen returned bits.
// - Rising first edge gives a 24-bit reply, eight pad bits first.
// - Falling first edge gives a 23-bit reply, seven pad bits first.
// - Selects 0-3 data registers, 4-7 control registers of A to D.
// - Selects 8-11 gain registers, 12-15 offset registers.
// - Selects 16-19 clear codes, 20-23 slew registers.
// - Select 24 status, 25 main control, 26 supply control.
// - Status word is read-only; writes change it only through the bit 11 user toggle.
// - With status-on-write set, status goes out on every write frame.
// - Bits 15:12 flag boost compliance loss and also set output fault.
// - Bit 11 is a user toggle set only by software register writes.
// - Bit 10 flags a failed packet check since status was last shifted out.
// - Bit 9 stays set while any channel is still ramping.
// - Bit 8 flags over-temperature from the on-chip detector.
// - Bits 3:0 flag current output faults; bits 7:4 are zero.
// - Slew register: enable bit 12, rate bits 6:3, step bits 2:0.
// - Status-on-write mode returns only the status word.
module serial_readback_status_regs
    import readback_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic sdin,
    output logic sdo,
    output logic sdo_oe,
    input wire logic addr_strap_hi,
    input wire logic addr_strap_lo,
    input wire logic [readback_pkg::N_CH-1:0] boost_compliance_flag,
    input wire logic [readback_pkg::N_CH-1:0] current_output_fault,
    input wire logic [readback_pkg::N_CH-1:0] ramp_busy,
    input wire logic over_temp,
    input wire logic packet_check_fail,
    input wire logic user_toggle_wr,
    input wire logic user_toggle_val,
    input wire logic status_on_write_enable,
    input wire logic slew_wr,
    input wire logic [1:0] slew_wr_ch,
    input wire logic [readback_pkg::DATA_W-1:0] slew_wr_data,
    output logic [readback_pkg::SEL_W-1:0] rd_sel,
    input wire logic [readback_pkg::DATA_W-1:0] rd_data,
    output logic [readback_pkg::N_CH-1:0] ramp_enable,
    output logic [readback_pkg::N_CH*readback_pkg::SLEW_RATE_W-1:0]
        ramp_update_rate,
    output logic [readback_pkg::N_CH*readback_pkg::SLEW_STEP_W-1:0]
        ramp_step_size,
    output logic [readback_pkg::DATA_W-1:0] fault_status,
    output logic read_pending
);
    import readback_pkg::*;

    readback_if rb ();

    // Pin levels that cross into the core clock domain
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_s;
    logic sync_n_s;
    logic [1:0] strap_s;
    logic [N_CH-1:0] boost_s;
    logic [N_CH-1:0] iout_s;
    logic [N_CH-1:0] ramp_s;
    logic temp_s;

    // Frame bookkeeping
    // The cmd decode is valid only at frame_done
    logic sync_n_prev_q;
    logic frame_done;
    logic frame_ok;
    logic [FRAME_W-1:0] cmd;
    logic addressed;
    logic is_read;
    logic [SEL_W-1:0] cmd_sel;

    // Reply and status state
    rb_state_t state_q;
    rb_state_t state_d;
    logic [SEL_W-1:0] sel_q;
    logic [DATA_W-1:0] reply_q;
    logic [DATA_W-1:0] reply_d;
    logic pend_q;
    logic reply_is_status_q;
    logic shown_status_q;
    logic [FRAME_W-1:0] tx_word_q;
    logic tx_en_q;
    logic [DATA_W-1:0] status_q;
    logic pkt_err_q;
    logic toggle_q;
    logic [DATA_W-1:0] slew_q [N_CH];

    // Link-side shifter on its own clock
    // Resets from select, not from reset
    serial_link u_link (
        .sclk(sclk),
        .sync_n(sync_n),
        .sdin(sdin),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .rb(rb.link)
    );

    // All asynchronous levels share one bank of two-flop synchronisers
    // Select enters inverted, so the zero
    // reset value reads as idle select
    assign pins_raw = {~sync_n, addr_strap_hi, addr_strap_lo, over_temp,
                       ramp_busy, current_output_fault,
                       boost_compliance_flag};

    bit_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(core_clk),
        .reset(reset),
        .din(pins_raw),
        .dout(pins_s)
    );

    // Split the synchronised bank back into named levels
    // Follows the concatenation order above
    assign boost_s = pins_s[N_CH-1:0];
    assign iout_s = pins_s[2*N_CH-1:N_CH];
    assign ramp_s = pins_s[3*N_CH-1:2*N_CH];
    assign temp_s = pins_s[3*N_CH];
    assign strap_s = pins_s[3*N_CH+2:3*N_CH+1];
    assign sync_n_s = ~pins_s[3*N_CH+3];

    // Select rising edge marks the end of a frame
    // Reset matches an idle select
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sync_n_prev_q <= 1'b1;
        end else begin
            sync_n_prev_q <= sync_n_s;
        end
    end

    // Seen 2-3 core cycles after select
    // rises; sets the gap between frames
    assign frame_done = sync_n_s & ~sync_n_prev_q;

    // Link clock is idle here, so the captured frame is stable to read.
    // A frame with a check byte carries the command in its top 24 bits.
    // Other lengths are dropped whole.
    // A select pulse with no clocks replays
    // the last capture; clock every frame
    always_comb begin
        frame_ok = (rb.rx_count == CNT_W'(FRAME_W)) ||
                   (rb.rx_count == CNT_W'(PC_FRAME_W));
        if (rb.rx_count == CNT_W'(PC_FRAME_W)) begin
            cmd = rb.rx_data[PC_FRAME_W-1:PC_FRAME_W-FRAME_W];
        end else begin
            cmd = rb.rx_data[FRAME_W-1:0];
        end
    end

    // Only the top eight command bits matter for a read
    // A cut frame cannot pose as a read
    assign addressed = (cmd[ADDR_MSB:ADDR_LSB] == strap_s);
    assign is_read = frame_ok & addressed & cmd[RW_POS];
    assign cmd_sel = cmd[SEL_MSB:SEL_LSB];

    // Read sequencer: latch the select, fetch, then hold the reply
    // ST_FETCH lets the register file
    // answer before ST_REPLY captures
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (frame_done && is_read) begin
                    state_d = ST_FETCH;
                end
            end
            ST_FETCH: begin
                state_d = ST_REPLY;
            end
            ST_REPLY: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer state register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Select register also drives the external register file lookup
    // Status-on-write steers reads to status
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sel_q <= '0;
        end else if (state_q == ST_IDLE && frame_done && is_read) begin
            sel_q <= status_on_write_enable ? SEL_STATUS
                                            : cmd_sel;
        end
    end

    // Flop output gives a clean address
    assign rd_sel = sel_q;

    // Decode of the select into a 16-bit value
    // Selects above 26 read back as zero
    always_comb begin
        reply_d = '0;
        if (sel_q <= SEL_CLEAR_D) begin
            reply_d = rd_data;
        end else if (sel_q <= SEL_SLEW_D) begin
            reply_d = slew_q[2'(sel_q - SEL_SLEW_A)];
        end else if (sel_q == SEL_STATUS) begin
            reply_d = status_q;
        end else if (sel_q == SEL_MAIN || sel_q == SEL_DCDC) begin
            reply_d = rd_data;
        end
    end

    // Reply becomes pending for exactly the next frame after the read
    // Captured once; later changes stay out
    always_ff @(posedge core_clk) begin
        if (reset) begin
            reply_q <= '0;
            pend_q <= 1'b0;
            reply_is_status_q <= 1'b0;
        end else if (state_q == ST_REPLY) begin
            reply_q <= reply_d;
            pend_q <= 1'b1;
            reply_is_status_q <= (sel_q == SEL_STATUS);
        end else if (frame_done) begin
            pend_q <= 1'b0;
        end
    end

    // Reply word is only refreshed between frames so the shifter never
    // sees it change mid-frame; this is why a setup gap is needed.
    // Status-on-write drives every frame
    // whatever its address: one device per
    // shared output may use it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_word_q <= '0;
            tx_en_q <= 1'b0;
            shown_status_q <= 1'b0;
        end else if (sync_n_s && state_q == ST_IDLE && !frame_done) begin
            if (pend_q) begin
                tx_word_q <= {{PAD_W{1'b0}}, reply_q};
                tx_en_q <= 1'b1;
                shown_status_q <= reply_is_status_q;
            end else begin
                tx_word_q <= {{PAD_W{1'b0}}, status_q};
                tx_en_q <= status_on_write_enable;
                shown_status_q <= status_on_write_enable;
            end
        end
    end

    // Handed to the shifter
    assign rb.tx_word = tx_word_q;
    assign rb.tx_en = tx_en_q;

    // Sticky packet-check error, cleared once status has been shifted
    // out; a new failure in the same cycle wins over the clear.
    // A status read clears it as well
    always_ff @(posedge core_clk) begin
        if (reset) begin
            pkt_err_q <= 1'b0;
        end else if (packet_check_fail) begin
            pkt_err_q <= 1'b1;
        end else if (frame_done && shown_status_q) begin
            pkt_err_q <= 1'b0;
        end
    end

    // User toggle follows software register writes only
    always_ff @(posedge core_clk) begin
        if (reset) begin
            toggle_q <= 1'b0;
        end else if (user_toggle_wr) begin
            toggle_q <= user_toggle_val;
        end
    end

    // Status word rebuilt every cycle from live sources; no write path
    // Bits 3:0 fold in compliance loss so
    // it also shows as an output fault
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= STATUS_RESET;
            status_q[ST_BOOST_LSB+N_CH-1:ST_BOOST_LSB] <= boost_s;
            status_q[ST_TOGGLE] <= toggle_q;
            status_q[ST_PKT] <= pkt_err_q;
            status_q[ST_RAMP] <= |ramp_s;
            status_q[ST_TEMP] <= temp_s;
            status_q[ST_IOUT_LSB+N_CH-1:ST_IOUT_LSB] <=
                iout_s | boost_s;
        end
    end

    // Straight from their flops
    assign fault_status = status_q;
    assign read_pending = pend_q;

    // Slew registers: reserved and ignored bits are stored as zero
    // A write lands at once
    genvar ch;
    generate
        for (ch = 0; ch < N_CH; ch++) begin : g_slew
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    slew_q[ch] <= SLEW_RESET;
                end else if (slew_wr && slew_wr_ch == 2'(ch)) begin
                    slew_q[ch] <= slew_wr_data & SLEW_KEEP;
                end
            end

            // Per-channel ramp controls come straight from the register
            assign ramp_enable[ch] = slew_q[ch][SLEW_EN_POS];
            assign ramp_update_rate[ch*SLEW_RATE_W +: SLEW_RATE_W] =
                slew_q[ch][SLEW_RATE_LSB +: SLEW_RATE_W];
            assign ramp_step_size[ch*SLEW_STEP_W +: SLEW_STEP_W] =
                slew_q[ch][SLEW_STEP_LSB +: SLEW_STEP_W];
        end
    endgenerate
endmodule : serial_readback_status_regs

// >>> readback_monitor.sv
// Purpose: Concurrent checks on the readback block's core-side ports
// Assumes: Sampled on core_clk, quiet while reset is high
// Notes: Async status inputs get slack for the synchroniser stages
`timescale 1ns/100ps
module readback_monitor
    import readback_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sync_n,
    input wire logic sdo_oe,
    input wire logic [readback_pkg::N_CH-1:0] ramp_busy,
    input wire logic over_temp,
    input wire logic packet_check_fail,
    input wire logic user_toggle_wr,
    input wire logic user_toggle_val,
    input wire logic slew_wr,
    input wire logic [1:0] slew_wr_ch,
    input wire logic [readback_pkg::DATA_W-1:0] slew_wr_data,
    input wire logic [readback_pkg::N_CH-1:0] ramp_enable,
    input wire logic [readback_pkg::N_CH*readback_pkg::SLEW_STEP_W-1:0]
        ramp_step_size,
    input wire logic [readback_pkg::DATA_W-1:0] fault_status,
    input wire logic read_pending
);
    default clocking mon_cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    // Pin is released once select has stood high a whole cycle
    property p_release;
        sync_n && $past(sync_n) |-> !sdo_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("serial output driven outside a frame");
    property p_armed_between;
        $rose(read_pending) |-> sync_n;
    endproperty
    a_armed_between: assert property (p_armed_between)
        else $error("reply armed inside a frame");
    property p_pad;
        fault_status[7:4] == 4'h0;
    endproperty
    a_pad: assert property (p_pad)
        else $error("status bits 7 to 4 not zero");
    // A compliance flag without its output fault would mislead the host
    property p_boost_fault;
        (fault_status[15:12] & ~fault_status[3:0]) == 4'h0;
    endproperty
    a_boost_fault: assert property (p_boost_fault)
        else $error("compliance flag without output fault");
    property p_temp;
        $rose(over_temp) ##1 over_temp[*4] |-> fault_status[ST_TEMP];
    endproperty
    a_temp: assert property (p_temp)
        else $error("over temperature bit not set");
    property p_ramp;
        (|ramp_busy)[*6] |-> fault_status[ST_RAMP];
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("ramp active bit not set");
    property p_pkt;
        packet_check_fail |-> ##[1:2] fault_status[ST_PKT];
    endproperty
    a_pkt: assert property (p_pkt)
        else $error("packet error bit not set");
    property p_toggle_ro;
        $changed(fault_status[ST_TOGGLE]) |->
            $past(user_toggle_wr) || $past(user_toggle_wr, 2);
    endproperty
    a_toggle_ro: assert property (p_toggle_ro)
        else $error("toggle bit changed without a write");
    property p_toggle;
        user_toggle_wr |-> ##[1:2] fault_status[ST_TOGGLE] == user_toggle_val;
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle bit did not follow the write");
    property p_slew;
        slew_wr |=> ramp_enable[$past(slew_wr_ch)] == $past(slew_wr_data[12])
            && ramp_step_size[3*$past(slew_wr_ch) +: 3] ==
            $past(slew_wr_data[2:0]);
    endproperty
    a_slew: assert property (p_slew)
        else $error("slew fields not loaded");
    c_pending: cover property (read_pending);
    c_slew: cover property (slew_wr);
    c_pkt: cover property (fault_status[ST_PKT]);
endmodule : readback_monitor

bind serial_readback_status_regs readback_monitor readback_monitor_i (.*);

// >>> host_model.sv
// Purpose: Host serial controller driving frames into the block
// Assumes: Link clock of 12 ns that stands still outside frames
// Notes: Idle level of the clock picks the first edge polarity
`timescale 1ns/100ps
module host_model (
    output logic sclk,
    output logic sync_n,
    output logic sdin,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // A released pin reads as the inverse of its last level
    wire logic line = sdo_oe ? sdo : !sdo;
    initial begin
        sclk = 1'b0;
        sync_n = 1'b1;
        sdin = 1'b0;
    end
    // One frame, MSB first; reply is shifted in on each fall after a rise
    task automatic xfer(input logic [23:0] word, input bit rise_first,
            output logic [23:0] got, output bit drove);
        got = 24'h000000;
        drove = 1'b0;
        sclk = !rise_first;
        #23.3 sync_n = 1'b0;
        #40;
        for (int i = 23; i >= 0; i--) begin
            if (rise_first) begin
                #6 sclk = 1'b1;
                sdin = word[i];
                #6 got = {got[22:0], line};
                sclk = 1'b0;
            end else begin
                sdin = word[i];
                #6 if (i < 23) got = {got[22:0], line};
                sclk = 1'b0;
                #6 sclk = 1'b1;
            end
            drove |= sdo_oe;
        end
        // Clock stands still between frames, so the reply is not disturbed
        #6 sync_n = 1'b1;
        sdin = !sdin;
        #100;
    endtask : xfer
endmodule : host_model

// >>> serial_readback_status_regs_bench.sv
// Purpose: Self-checking bench for the readback and status block
// Assumes: Core inputs change on falling core_clk edges
// Notes: External register file answers {C3, 0, select}
`timescale 1ns/100ps
module serial_readback_status_regs_bench;
    import readback_pkg::*;
    typedef struct {logic [4:0] sel; bit rise; logic [15:0] exp;} row_t;
    logic core_clk, reset, sclk, sync_n, sdin, sdo, sdo_oe;
    logic over_temp, packet_check_fail, user_toggle_wr, user_toggle_val;
    logic status_on_write_enable, slew_wr, read_pending, drove;
    logic [3:0] boost, iout, ramp_busy, ramp_enable;
    logic [1:0] slew_wr_ch;
    logic [4:0] rd_sel;
    logic [15:0] slew_wr_data, rd_data, ramp_update_rate, fault_status;
    logic [11:0] ramp_step_size;
    logic [23:0] got;
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    row_t rows [13] = '{'{5'h00, 1, 16'hC300}, '{5'h03, 0, 16'hC303},
        '{5'h07, 1, 16'hC307}, '{5'h0B, 0, 16'hC30B}, '{5'h0F, 1, 16'hC30F},
        '{5'h13, 0, 16'hC313}, '{5'h14, 1, 16'h107F}, '{5'h17, 0, 16'h0028},
        '{5'h18, 1, 16'h2B06}, '{5'h19, 0, 16'hC319}, '{5'h1A, 1, 16'hC31A},
        '{5'h1B, 0, 16'h0000}, '{5'h1F, 1, 16'h0000}};
    assign rd_data = {8'hC3, 3'h0, rd_sel};
    serial_readback_status_regs serial_readback_status_regs_i (
        .core_clk(core_clk), .reset(reset), .sclk(sclk), .sync_n(sync_n),
        .sdin(sdin), .sdo(sdo), .sdo_oe(sdo_oe), .addr_strap_hi(1'b1),
        .addr_strap_lo(1'b0), .boost_compliance_flag(boost),
        .current_output_fault(iout), .ramp_busy(ramp_busy),
        .over_temp(over_temp), .packet_check_fail(packet_check_fail),
        .user_toggle_wr(user_toggle_wr), .user_toggle_val(user_toggle_val),
        .status_on_write_enable(status_on_write_enable), .slew_wr(slew_wr),
        .slew_wr_ch(slew_wr_ch), .slew_wr_data(slew_wr_data),
        .rd_sel(rd_sel), .rd_data(rd_data), .ramp_enable(ramp_enable),
        .ramp_update_rate(ramp_update_rate),
        .ramp_step_size(ramp_step_size), .fault_status(fault_status),
        .read_pending(read_pending));
    host_model host_model_i (.sclk(sclk), .sync_n(sync_n), .sdin(sdin),
        .sdo(sdo), .sdo_oe(sdo_oe));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Run is about 1500 cycles; the ceiling leaves ample margin
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            results();
        end
    end
    function automatic logic [23:0] cmd(logic [4:0] sel, logic [1:0] a);
        return {1'b1, a, sel, 16'h5A3C};
    endfunction : cmd
    function automatic logic [23:0] no_operation_frame(logic [1:0] a);
        return NO_OP_FRAME | {1'b0, a, 21'h0};
    endfunction : no_operation_frame
    task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic slew(logic [1:0] ch, logic [15:0] d);
        @(negedge core_clk);
        slew_wr = 1'b1;
        slew_wr_ch = ch;
        slew_wr_data = d;
        @(negedge core_clk);
        slew_wr = 1'b0;
    endtask : slew
    task automatic results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    initial begin
        reset = 1'b1;
        {boost, iout, ramp_busy} = 12'h241;
        {over_temp, packet_check_fail, user_toggle_wr} = 3'h0;
        {user_toggle_val, status_on_write_enable, slew_wr} = 3'h0;
        slew_wr_ch = 2'h0;
        slew_wr_data = 16'h0000;
        repeat (6) @(negedge core_clk);
        check("status", fault_status, 0);
        check("pending", read_pending, 0);
        check("enable", ramp_enable, 0);
        reset = 1'b0;
        over_temp = 1'b1;
        user_toggle_val = 1'b1;
        user_toggle_wr = 1'b1;
        @(negedge core_clk);
        user_toggle_wr = 1'b0;
        slew(2'h0, 16'hFFFF);
        slew(2'h3, 16'hA5A8);
        repeat (10) @(negedge core_clk);
        check("enable", ramp_enable, 4'h1);
        check("rate", ramp_update_rate, 16'h500F);
        check("step", ramp_step_size, 12'h007);
        check("status", fault_status, 16'h2B06);
        foreach (rows[i]) begin
            host_model_i.xfer(cmd(rows[i].sel, 2'h2), 1'b1, got, drove);
            check("read frame drive", drove, 0);
            check("pending", read_pending, 1);
            host_model_i.xfer(no_operation_frame(2'h2), rows[i].rise, got, drove);
            check("reply drive", drove, 1);
            check("reply", got[15:0], rows[i].exp);
        end
        // Foreign address: nothing armed, pin left alone
        host_model_i.xfer(cmd(5'h00, 2'h1), 1'b1, got, drove);
        check("pending", read_pending, 0);
        host_model_i.xfer(no_operation_frame(2'h1), 1'b0, got, drove);
        check("foreign drive", drove, 0);
        host_model_i.xfer(cmd(5'h0B, 2'h2), 1'b0, got, drove);
        host_model_i.xfer(cmd(5'h18, 2'h2), 1'b0, got, drove);
        check("chained reply", got[15:0], 16'hC30B);
        host_model_i.xfer(no_operation_frame(2'h2), 1'b1, got, drove);
        check("chained status", got[15:0], 16'h2B06);
        @(negedge core_clk);
        packet_check_fail = 1'b1;
        @(negedge core_clk);
        packet_check_fail = 1'b0;
        status_on_write_enable = 1'b1;
        repeat (3) @(negedge core_clk);
        check("packet bit", fault_status[10], 1);
        host_model_i.xfer(24'h4E1234, 1'b1, got, drove);
        check("status on write", got[15:0], 16'h2F06);
        check("packet cleared", fault_status[10], 0);
        host_model_i.xfer(cmd(5'h00, 2'h2), 1'b1, got, drove);
        host_model_i.xfer(no_operation_frame(2'h2), 1'b0, got, drove);
        check("status only", got[15:0], 16'h2B06);
        results();
    end
endmodule : serial_readback_status_regs_bench
